// >>> design/scip_map.svh
/*
 * Register map of the smart card interrupt pending block: offsets, field
 * positions, reset values and the unmapped read value.
 * Assumes a 32-bit Avalon-MM slave with word addressing in bytes.
 */
`ifndef SCIP_MAP_SVH
`define SCIP_MAP_SVH

`define SCIP_ADDR_W          4
`define SCIP_OFS_PENDING     4'h0
`define SCIP_OFS_ENABLE      4'h4
`define SCIP_OFS_IRQ_STATUS  4'h8
`define SCIP_OFS_IRQ_MASK    4'hC

`define SCIP_BIT_TXBE        7
`define SCIP_BIT_UNUSED      6
`define SCIP_BIT_OVERCUR     5
`define SCIP_BIT_VOLT        4
`define SCIP_BIT_WAIT        3
`define SCIP_BIT_SENT        2
`define SCIP_BIT_RECV        1
`define SCIP_BIT_PARITY      0

`define SCIP_FLAG_MASK       8'hBF
`define SCIP_RST_PENDING     8'h00
`define SCIP_RST_ENABLE      8'h00
`define SCIP_RST_IRQ         8'h00
`define SCIP_UNMAPPED_DATA   32'h0000_0000

`endif

// >>> design/scip_pkg.sv
/*
 * Types shared by the smart card interrupt pending block.
 * Assumes scip_map.svh gives the numbers.
 */
package scip_pkg;
  typedef enum logic [2:0] {
    SCIP_IDLE = 3'b001,
    SCIP_ACK  = 3'b010,
    SCIP_DONE = 3'b100
  } scip_bus_state_type;

  typedef logic [7:0] scip_flags_type;
endpackage

// >>> design/scip_regs_if.sv
/*
 * Interface carrying decoded register accesses from the bus slave to the
 * flag register bank.
 * Assumes one clock domain; strobes are single-cycle pulses.
 */
`timescale 1ns/10ps
`default_nettype none
interface scip_regs_if;
  import scip_pkg::*;
  logic           rd_pending;
  logic           wr_enable;
  logic           wr_irq_status;
  logic           wr_irq_mask;
  scip_flags_type wdata;
  scip_flags_type pending;
  scip_flags_type enable;
  scip_flags_type irq_status;
  scip_flags_type irq_mask;

  modport bus  (output rd_pending, wr_enable, wr_irq_status, wr_irq_mask, wdata,
                input  pending, enable, irq_status, irq_mask);
  modport bank (input  rd_pending, wr_enable, wr_irq_status, wr_irq_mask, wdata,
                output pending, enable, irq_status, irq_mask);
endinterface
`default_nettype wire

// >>> design/scip_flag_bank.sv
/*
 * Pending flags, enable register, interrupt status and mask.
 * Assumes event inputs are synchronous single-cycle or level strobes.
 */
`timescale 1ns/10ps
`default_nettype none
`include "scip_map.svh"
module scip_flag_bank
  import scip_pkg::*;
(
  input  wire logic     clk,
  input  wire logic     arst_n,
  input  wire logic [7:0] events,
  scip_regs_if.bank     regs
);
  scip_flags_type pending;
  scip_flags_type enable;
  scip_flags_type irq_status;
  scip_flags_type irq_mask;
  scip_flags_type next_pending;
  scip_flags_type next_enable;
  scip_flags_type next_irq_status;
  scip_flags_type next_irq_mask;
  scip_flags_type gated;

  always_comb begin
    gated = events & enable & `SCIP_FLAG_MASK;
    next_pending = pending;
    if (regs.rd_pending) begin
      next_pending = `SCIP_RST_PENDING;
    end
    next_pending = next_pending | gated;                   // set beats the clearing read
    next_enable = enable;
    if (regs.wr_enable) begin
      next_enable = regs.wdata & `SCIP_FLAG_MASK;
    end
    next_irq_status = irq_status;
    if (regs.wr_irq_status) begin
      next_irq_status = irq_status & ~regs.wdata;
    end
    next_irq_status = (next_irq_status | gated) & `SCIP_FLAG_MASK;
    next_irq_mask = irq_mask;
    if (regs.wr_irq_mask) begin
      next_irq_mask = regs.wdata & `SCIP_FLAG_MASK;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pending    <= `SCIP_RST_PENDING;
      enable     <= `SCIP_RST_ENABLE;
      irq_status <= `SCIP_RST_IRQ;
      irq_mask   <= `SCIP_RST_IRQ;
    end else begin
      pending    <= next_pending;
      enable     <= next_enable;
      irq_status <= next_irq_status;
      irq_mask   <= next_irq_mask;
    end
  end

  assign regs.pending    = pending;
  assign regs.enable     = enable;
  assign regs.irq_status = irq_status;
  assign regs.irq_mask   = irq_mask;
endmodule
`default_nettype wire

// >>> design/scip_top.sv
/*
 * Smart card interrupt pending block with an Avalon-MM register slave.
 * Assumes a master that holds its request until waitrequest is low.
 */
// The register offsets and the Avalon-MM slave port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "scip_map.svh"
module scip_top
  import scip_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    arst_n,
  input  wire logic [`SCIP_ADDR_W-1:0] avs_address,
  input  wire logic                    avs_read,
  input  wire logic                    avs_write,
  input  wire logic [31:0]             avs_writedata,
  input  wire logic [3:0]              avs_byteenable,
  output var  logic [31:0]             avs_readdata,
  output var  logic                    avs_waitrequest,
  output var  logic                    irq,
  input  wire logic                    tx_buffer_empty,
  input  wire logic                    card_overcurrent,
  input  wire logic                    card_voltage_fault,
  input  wire logic                    wait_underflow,
  input  wire logic                    char_sent,
  input  wire logic                    char_received,
  input  wire logic                    parity_fault
);
  scip_regs_if regs ();

  scip_bus_state_type state;
  scip_bus_state_type next_state;
  logic [31:0]        next_readdata;
  logic               next_waitrequest;
  logic               next_irq;
  logic [7:0]         events;
  logic               lane0;

  function automatic logic hit(input logic [`SCIP_ADDR_W-1:0] a, input logic [`SCIP_ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction

  always_comb begin
    events = 8'h00;
    events[`SCIP_BIT_TXBE]    = tx_buffer_empty;
    events[`SCIP_BIT_OVERCUR] = card_overcurrent;
    events[`SCIP_BIT_VOLT]    = card_voltage_fault;
    events[`SCIP_BIT_WAIT]    = wait_underflow;
    events[`SCIP_BIT_SENT]    = char_sent;
    events[`SCIP_BIT_RECV]    = char_received;
    events[`SCIP_BIT_PARITY]  = parity_fault;
  end

  scip_flag_bank u_bank (
    .clk    (clk),
    .arst_n (arst_n),
    .events (events),
    .regs   (regs)
  );

  // clear shares the snapshot edge, so no event slips in between snapshot and clear
  // writes land in ACK and need byteenable[0]; each strobe fires once per request if the request drops before the FSM is back in IDLE
  assign lane0                  = avs_byteenable[0];
  assign regs.rd_pending        = (state == SCIP_IDLE) && avs_read && hit(avs_address, `SCIP_OFS_PENDING);
  assign regs.wr_enable         = (state == SCIP_ACK) && avs_write && lane0 && hit(avs_address, `SCIP_OFS_ENABLE);
  assign regs.wr_irq_status     = (state == SCIP_ACK) && avs_write && lane0 && hit(avs_address, `SCIP_OFS_IRQ_STATUS);
  assign regs.wr_irq_mask       = (state == SCIP_ACK) && avs_write && lane0 && hit(avs_address, `SCIP_OFS_IRQ_MASK);
  assign regs.wdata             = avs_writedata[7:0];

  always_comb begin
    next_state       = state;
    next_readdata    = avs_readdata;
    next_waitrequest = 1'b1;
    case (state)
      SCIP_IDLE: begin
        if (avs_read || avs_write) begin
          next_state       = SCIP_ACK;
          next_waitrequest = 1'b0;
          next_readdata    = `SCIP_UNMAPPED_DATA;
          if (avs_read) begin
            if (hit(avs_address, `SCIP_OFS_PENDING)) begin
              next_readdata = {24'h000000, regs.pending};   // bit 6 stays 0
            end else if (hit(avs_address, `SCIP_OFS_ENABLE)) begin
              next_readdata = {24'h000000, regs.enable};
            end else if (hit(avs_address, `SCIP_OFS_IRQ_STATUS)) begin
              next_readdata = {24'h000000, regs.irq_status};
            end else if (hit(avs_address, `SCIP_OFS_IRQ_MASK)) begin
              next_readdata = {24'h000000, regs.irq_mask};
            end
          end
        end
      end
      SCIP_ACK: begin
        next_state = SCIP_DONE;
      end
      SCIP_DONE: begin
        next_state = SCIP_IDLE;
      end
      default: begin
        next_state = SCIP_IDLE;
      end
    endcase
    next_irq = |(regs.irq_status & regs.irq_mask);
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state           <= SCIP_IDLE;
      avs_readdata    <= 32'h0000_0000;
      avs_waitrequest <= 1'b1;
      irq             <= 1'b0;
    end else begin
      state           <= next_state;
      avs_readdata    <= next_readdata;
      avs_waitrequest <= next_waitrequest;
      irq             <= next_irq;
    end
  end
endmodule
`default_nettype wire

// >>> tb/scip_checker.sv
/*
 * Bus and flag checks for the smart card pending block.
 * Assumes binding to the ports of scip_top.
 */
`timescale 1ns/10ps
`default_nettype none
`include "scip_map.svh"
module scip_checker (
  input wire logic                    clk,
  input wire logic                    arst_n,
  input wire logic [`SCIP_ADDR_W-1:0] avs_address,
  input wire logic                    avs_read,
  input wire logic                    avs_write,
  input wire logic [31:0]             avs_readdata,
  input wire logic                    avs_waitrequest,
  input wire logic                    irq,
  input wire logic                    tx_buffer_empty,
  input wire logic                    card_overcurrent,
  input wire logic                    card_voltage_fault,
  input wire logic                    wait_underflow,
  input wire logic                    char_sent,
  input wire logic                    char_received,
  input wire logic                    parity_fault
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  logic ev;
  logic ack;
  logic wr_ack;
  logic clean;
  logic ev_d;
  assign ev = tx_buffer_empty | card_overcurrent | card_voltage_fault | wait_underflow | char_sent | char_received
              | parity_fault;
  assign ack = !avs_waitrequest;
  assign wr_ack = ack & avs_write;
  // event seen on the request edge of a clearing read survives it
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n) ev_d <= 1'b0;
    else ev_d <= ev;
  // no event since the last clearing read, so flags must be empty
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n) clean <= 1'b1;
    else if (ev) clean <= 1'b0;
    else if (ack && avs_read && avs_address == 4'h0 && !ev_d) clean <= 1'b1;
  property p_ack_pulse; ack |=> avs_waitrequest; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_ack_req; ack |-> avs_read || avs_write; endproperty
  a_ack_req: assert property (p_ack_req) else $error("ack without request");
  property p_ack_bound; $rose(avs_read) |-> ##[1:4] ack; endproperty
  a_ack_bound: assert property (p_ack_bound) else $error("read not answered");
  property p_upper; ack && avs_read |-> avs_readdata[31:8] == 24'h000000; endproperty
  a_upper: assert property (p_upper) else $error("upper read bits set");
  property p_bit6; ack && avs_read && !avs_address[3] |-> !avs_readdata[6]; endproperty
  a_bit6: assert property (p_bit6) else $error("bit 6 reads one");
  property p_clear; ack && avs_read && avs_address == 4'h0 && clean |-> avs_readdata[7:0] == 8'h00; endproperty
  a_clear: assert property (p_clear) else $error("flag survived clearing read");
  property p_unmapped; ack && avs_read && avs_address[1:0] != 2'h0 |-> avs_readdata == 32'h00000000; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_irq_rise; $rose(irq) |-> $past(ev) || $past(ev, 2) || $past(wr_ack) || $past(wr_ack, 2); endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("irq rose without cause");
  property p_irq_fall; $fell(irq) |-> $past(wr_ack) || $past(wr_ack, 2); endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq fell without write");
endmodule
bind scip_top scip_checker i_scip_checker (.clk(clk), .arst_n(arst_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .irq(irq), .tx_buffer_empty(tx_buffer_empty), .card_overcurrent(card_overcurrent),
  .card_voltage_fault(card_voltage_fault), .wait_underflow(wait_underflow), .char_sent(char_sent),
  .char_received(char_received), .parity_fault(parity_fault));
`default_nettype wire

// >>> tb/tb.sv
/*
 * Self-checking bench for the smart card pending block.
 * Assumes scip_top with a one-cycle Avalon-MM answer.
 */
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic        clk;
  logic        arst_n;
  logic        avs_read;
  logic        avs_write;
  logic        avs_waitrequest;
  logic        irq;
  logic [3:0]  avs_address;
  logic [3:0]  be;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic [31:0] q;
  logic [7:0]  ev;
  int          bad_count;
  int          compares;
  scip_top i_scip_top (.clk(clk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(be), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq), .tx_buffer_empty(ev[7]), .card_overcurrent(ev[5]),
    .card_voltage_fault(ev[4]), .wait_underflow(ev[3]), .char_sent(ev[2]), .char_received(ev[1]),
    .parity_fault(ev[0]));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic print_verdict;
    $display("mismatches %0d comparisons %0d", bad_count, compares);
    if (bad_count == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  // request held until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !w;
    avs_write <= w;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h00000000);
    chk(q, e);
  endtask
  task automatic pulse(input logic [7:0] m);
    @(posedge clk);
    ev <= m;
    @(posedge clk);
    ev <= 8'h00;
    // irq registers one edge after the status bit
    repeat (2) @(posedge clk);
  endtask
  task automatic t_reset;
    rd(4'h0, 32'h00000000);
    rd(4'h4, 32'h00000000);
    chk({31'h0, irq}, 32'h00000000);
  endtask
  task automatic t_flags;
    pulse(8'hFF);
    rd(4'h0, 32'h00000000);
    bus(1'b1, 4'h4, 32'hFFFFFFFF);
    rd(4'h4, 32'h000000BF);
    for (int i = 0; i < 8; i++) begin
      if (i != 6) begin
        pulse(8'h01 << i);
        rd(4'h0, 32'h00000001 << i);
        rd(4'h0, 32'h00000000);
      end
    end
    pulse(8'h01);
    bus(1'b1, 4'h0, 32'h00000000);
    rd(4'h0, 32'h00000001);
  endtask
  // parity event on the clearing edge, then on the answer edge; both must survive
  task automatic t_same;
    for (int k = 1; k < 3; k++) begin
      fork
        rd(4'h0, 32'h00000000);
        begin
          repeat (k) @(posedge clk);
          ev <= 8'h01;
          @(posedge clk);
          ev <= 8'h00;
        end
      join
      rd(4'h0, 32'h00000001);
    end
  endtask
  task automatic t_irq;
    bus(1'b1, 4'h8, 32'h000000FF);
    bus(1'b1, 4'hC, 32'h00000001);
    rd(4'hC, 32'h00000001);
    pulse(8'h01);
    chk({31'h0, irq}, 32'h00000001);
    rd(4'h8, 32'h00000001);
    bus(1'b1, 4'h8, 32'h00000001);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h00000000);
    bus(1'b1, 4'hC, 32'h00000000);
    pulse(8'h01);
    chk({31'h0, irq}, 32'h00000000);
    be <= 4'h0;
    bus(1'b1, 4'h4, 32'h00000000);
    be <= 4'hF;
    rd(4'h4, 32'h000000BF);
    rd(4'h2, 32'h00000000);
  endtask
  initial begin
    arst_n = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 4'h0;
    avs_writedata = 32'h00000000;
    be = 4'hF;
    ev = 8'h00;
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    t_reset();
    t_flags();
    t_same();
    t_irq();
    print_verdict();
  end
  // whole run needs well under 500 cycles
  initial begin
    repeat (3000) @(posedge clk);
    bad_count++;
    $display("[ERR] %0t watchdog expired", $time);
    print_verdict();
  end
endmodule
`default_nettype wire
